/* lock_status_defines.svh */
// Constants for the lock status and dead-zone block: offsets, fields, resets, timing.
// Assumes a 100 MHz pclk and a 32-bit APB register word per offset.
`ifndef LOCK_STATUS_DEFINES_SVH
`define LOCK_STATUS_DEFINES_SVH

// Register byte offsets
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_IF_COUNT 12'h008
`define OFF_IRQ_STAT 12'h00c
`define OFF_IRQ_MASK 12'h010
`define OFF_DIVISOR 12'h014

// Control register fields
`define CTRL_DZ_LO 0
`define CTRL_DZ_HI 1
`define CTRL_OSEL_LO 2
`define CTRL_OSEL_HI 3
`define CTRL_CTE 4
`define CTRL_RESET 5'h00

// Status and interrupt fields
`define ST_LOCKED 0
`define ST_UNLOCK 1
`define ST_IF_DONE 2
`define ST_STATION 3
`define ST_PORT 4
`define ST_ONON 5
`define IRQ_UNLOCK 0
`define IRQ_RELOCK 1
`define IRQ_IF_DONE 2
`define IRQ_RESET 3'h0
`define DIVISOR_RESET 16'h0000

// Timing
`define CLK_PERIOD_NS 10
`define CLK_MHZ 100
`define GATE_TIME_US 4000
`define DZ_C_NS 20
`define DZ_D_NS 50
`define ONON_A_NS 30
`define ONON_B_NS 10
`define LOCK_WIN_NS 100
`define DZ_C_CYC ((`DZ_C_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DZ_D_CYC ((`DZ_D_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ONON_A_CYC ((`ONON_A_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ONON_B_CYC ((`ONON_B_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOCK_WIN_CYC (`LOCK_WIN_NS / `CLK_PERIOD_NS)

`endif

/* lock_status_pkg.sv */
// Types for the lock status and dead-zone block.
// Assumes constants come from lock_status_defines.svh.
package lock_status_pkg;
    // Dead-zone modes, as the two-bit control field encodes them
    typedef enum logic [1:0] {
        no_gap_mode_a = 2'h0,
        no_gap_mode_b = 2'h1,
        gap_mode_c = 2'h2,
        gap_mode_d = 2'h3
    } dead_zone_t;
    // Source of the serial output pin
    typedef enum logic [1:0] {
        out_lock = 2'h0,
        out_if_done = 2'h1,
        out_port = 2'h2,
        out_no_unlock = 2'h3
    } out_sel_t;
    // IF counter sequence
    typedef enum logic [2:0] {
        if_idle = 3'h1,
        if_run = 3'h2,
        if_end = 3'h4
    } if_state_t;
endpackage

/* pd_if.sv */
// Carrier between the top and the phase comparator.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
`default_nettype none
interface pd_if;
    lock_status_pkg::dead_zone_t dz_sel;
    logic up;
    logic dn;
    logic lock_tick;
    logic lock_ok;
    modport cmp (input dz_sel, output up, output dn, output lock_tick, output lock_ok);
    modport ctl (output dz_sel, input up, input dn, input lock_tick, input lock_ok);
endinterface
`default_nettype wire

/* pin_sync.sv */
// Three-stage pin synchroniser with agreement filter, one per bit.
// Assumes inputs are asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 5
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, low
    input wire logic [W-1:0] d, // Raw pins
    output logic [W-1:0] q // Filtered levels
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1, s2, s3;
            // Output moves only when the last two stages agree
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    s1 <= d[i];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        q[i] <= s3;
                    end
                end
            end
        end
    endgenerate
endmodule // pin_sync
`default_nettype wire

/* phase_compare.sv */
// Phase-frequency comparator with dead-zone control and per-period lock verdict.
// Assumes synchronised reference and divided oscillator levels on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "lock_status_defines.svh"
module phase_compare (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, low
    input wire logic ref_lvl, // Reference phase level
    input wire logic osc_lvl, // Divided oscillator level
    pd_if.cmp pd // Pump and lock carrier
);
    logic ref_d, osc_d, up_st, dn_st, onon;
    logic [7:0] hold_cnt, err_cnt, err_max, dz_cyc, hold_cyc;
    logic [1:0] osc_edges;
    wire logic ref_rise = ref_lvl & ~ref_d;
    wire logic osc_rise = osc_lvl & ~osc_d;

    // Scheme and widths from the dead-zone field
    always_comb begin
        onon = ~pd.dz_sel[1];
        case (pd.dz_sel)
            lock_status_pkg::no_gap_mode_a: begin dz_cyc = 8'h00; hold_cyc = 8'(`ONON_A_CYC); end
            lock_status_pkg::no_gap_mode_b: begin dz_cyc = 8'h00; hold_cyc = 8'(`ONON_B_CYC); end
            lock_status_pkg::gap_mode_c: begin dz_cyc = 8'(`DZ_C_CYC); hold_cyc = 8'h00; end
            default: begin dz_cyc = 8'(`DZ_D_CYC); hold_cyc = 8'h00; end
        endcase
    end

    // Edge memory
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_d <= 1'b0;
            osc_d <= 1'b0;
        end else begin
            ref_d <= ref_lvl;
            osc_d <= osc_lvl;
        end
    end

    // Detector state; ON/ON keeps both sides on briefly so locked loops still pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_st <= 1'b0;
            dn_st <= 1'b0;
            hold_cnt <= 8'h00;
        end else if (hold_cnt != 8'h00) begin
            hold_cnt <= hold_cnt - 8'h01;
            if (hold_cnt == 8'h01) begin
                up_st <= 1'b0;
                dn_st <= 1'b0;
            end
        end else if ((up_st | ref_rise) & (dn_st | osc_rise)) begin
            up_st <= onon;
            dn_st <= onon;
            hold_cnt <= onon ? hold_cyc : 8'h00;
        end else begin
            up_st <= up_st | ref_rise;
            dn_st <= dn_st | osc_rise;
        end
    end

    // Error width, masked by the dead zone in OFF/OFF
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_cnt <= 8'h00;
            pd.up <= 1'b0;
            pd.dn <= 1'b0;
        end else begin
            err_cnt <= (up_st ^ dn_st) ? ((err_cnt == 8'hff) ? err_cnt : err_cnt + 8'h01) : 8'h00;
            pd.up <= up_st & (onon | (err_cnt >= dz_cyc));
            pd.dn <= dn_st & (onon | (err_cnt >= dz_cyc));
        end
    end

    // Verdict at each reference edge over the period just ended
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_max <= 8'h00;
            osc_edges <= 2'h0;
            pd.lock_tick <= 1'b0;
            pd.lock_ok <= 1'b0;
        end else if (ref_rise) begin
            pd.lock_tick <= 1'b1;
            pd.lock_ok <= (osc_edges == 2'h1) && (err_max <= 8'(`LOCK_WIN_CYC));
            err_max <= 8'h00;
            osc_edges <= {1'b0, osc_rise};
        end else begin
            pd.lock_tick <= 1'b0;
            err_max <= (err_cnt > err_max) ? err_cnt : err_max;
            if (osc_rise && osc_edges != 2'h3) begin
                osc_edges <= osc_edges + 2'h1;
            end
        end
    end
endmodule // phase_compare
`default_nettype wire

/* lock_status_top.sv */
// Lock status reporting, dead-zone selection and IF counter control behind APB.
// Assumes pins are asynchronous to pclk and a standard APB master.
//
// Functional notes
// - In lock mode the serial output is high while locked and low while unlocked.
// - Lock mode shows the live lock state, not the sticky unlock flag.
// - Dead-zone codes 00 and 01 give no dead zone with the ON/ON pump scheme.
// - Dead-zone codes 10 and 11 give a dead zone with the OFF/OFF pump scheme.
// - In ON/ON the comparator keeps issuing correction pulses while locked.
// - The serial output can signal that the IF count has finished.
// - The serial output can copy an input port pin unchanged.
// - The unlock flag stays set until the next register read or write of the block.
// - Clearing count enable resets the IF counter and a 0 to 1 change starts a count.
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lock_status_defines.svh"
module lock_status_top #(
    parameter int unsigned GATE_CYCLES = `GATE_TIME_US * `CLK_MHZ
) (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, low
    input wire logic [11:0] paddr, // APB address
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic ref_phase_in, // Reference phase pin
    input wire logic osc_phase_in, // Divided oscillator pin
    input wire logic if_signal_input, // IF signal pin
    input wire logic station_detect, // Station detect pin
    input wire logic port_pin_in, // Input port pin
    output logic serial_out, // Serial output pin level
    output logic pump_up, // Charge pump up
    output logic pump_dn, // Charge pump down
    output logic [15:0] divisor_out, // Divisor to the divider
    output logic irq // Level interrupt
);
    pd_if pd ();
    logic [4:0] pins_q;
    logic ref_lvl, osc_lvl, if_lvl, sd_lvl, port_lvl;
    logic [4:0] ctrl_reg;
    logic [15:0] divisor_reg;
    logic locked_reg, unlock_reg, if_done_reg, cte_prev_reg, if_d_reg;
    logic [19:0] if_count_reg, gate_reg;
    logic [2:0] irq_stat_reg, irq_mask_reg, irq_event;
    lock_status_pkg::if_state_t if_state_reg, if_state_next;
    lock_status_pkg::out_sel_t out_sel;
    logic access, commit, wr_commit, rd_commit, addr_ok;
    logic [31:0] rdata_next;
    logic if_rise, if_count_enable, cte_start;

    // All pins through the agreement synchroniser
    pin_sync #(.W(5)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({port_pin_in, station_detect, if_signal_input, osc_phase_in, ref_phase_in}),
        .q(pins_q)
    );
    assign ref_lvl = pins_q[0];
    assign osc_lvl = pins_q[1];
    assign if_lvl = pins_q[2];
    assign sd_lvl = pins_q[3];
    assign port_lvl = pins_q[4];

    phase_compare u_pc (
        .pclk(pclk),
        .presetn(presetn),
        .ref_lvl(ref_lvl),
        .osc_lvl(osc_lvl),
        .pd(pd.cmp)
    );

    // Dead-zone field drives the comparator directly
    assign pd.dz_sel = lock_status_pkg::dead_zone_t'(ctrl_reg[`CTRL_DZ_HI:`CTRL_DZ_LO]);
    assign out_sel = lock_status_pkg::out_sel_t'(ctrl_reg[`CTRL_OSEL_HI:`CTRL_OSEL_LO]);
    assign if_count_enable = ctrl_reg[`CTRL_CTE];

    // APB decode; one wait state so read data come from a flop
    assign access = psel & penable;
    assign commit = access & pready;
    assign wr_commit = commit & pwrite & addr_ok;
    assign rd_commit = commit & ~pwrite & addr_ok;

    always_comb begin
        addr_ok = 1'b1;
        rdata_next = 32'h0000_0000;
        case (paddr)
            `OFF_CTRL: rdata_next[4:0] = ctrl_reg;
            `OFF_STATUS: begin
                rdata_next[`ST_LOCKED] = locked_reg;
                rdata_next[`ST_UNLOCK] = unlock_reg;
                rdata_next[`ST_IF_DONE] = if_done_reg;
                rdata_next[`ST_STATION] = sd_lvl; // Lets software gate IF counting on it
                rdata_next[`ST_PORT] = port_lvl;
                rdata_next[`ST_ONON] = ~ctrl_reg[`CTRL_DZ_HI];
            end
            `OFF_IF_COUNT: rdata_next[19:0] = if_count_reg;
            `OFF_IRQ_STAT: rdata_next[2:0] = irq_stat_reg;
            `OFF_IRQ_MASK: rdata_next[2:0] = irq_mask_reg;
            `OFF_DIVISOR: rdata_next[15:0] = divisor_reg;
            default: addr_ok = 1'b0;
        endcase
    end

    // Bus answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access & ~pready;
            pslverr <= access & ~pready & ~addr_ok;
            if (access & ~pready & ~pwrite) begin
                prdata <= rdata_next;
            end
        end
    end

    // Control word; a write latches all selections at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (wr_commit && paddr == `OFF_CTRL) begin
            ctrl_reg <= pwdata[4:0];
        end
    end

    // Divisor; lock output lags it by up to two reference periods
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divisor_reg <= `DIVISOR_RESET;
        end else if (wr_commit && paddr == `OFF_DIVISOR) begin
            divisor_reg <= pwdata[15:0];
        end
    end

    // Live lock state from the per-period verdict
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_reg <= 1'b0;
        end else if (pd.lock_tick) begin
            locked_reg <= pd.lock_ok;
        end
    end

    // Sticky unlock flag; a new unlock beats the clearing access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_reg <= 1'b0;
        end else if (pd.lock_tick && !pd.lock_ok) begin
            unlock_reg <= 1'b1;
        end else if (rd_commit || wr_commit) begin
            unlock_reg <= 1'b0;
        end
    end

    // IF edge and count-enable edge detection
    assign if_rise = if_lvl & ~if_d_reg;
    assign cte_start = if_count_enable & ~cte_prev_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            if_d_reg <= 1'b0;
            cte_prev_reg <= 1'b0;
        end else begin
            if_d_reg <= if_lvl;
            cte_prev_reg <= if_count_enable;
        end
    end

    // IF counter sequence
    always_comb begin
        case (if_state_reg)
            lock_status_pkg::if_idle: if_state_next = cte_start ? lock_status_pkg::if_run : if_state_reg;
            lock_status_pkg::if_run: if_state_next = (gate_reg == 20'h00001) ? lock_status_pkg::if_end
                                                                              : if_state_reg;
            lock_status_pkg::if_end: if_state_next = if_state_reg;
            default: if_state_next = lock_status_pkg::if_idle;
        endcase
        if (!if_count_enable) begin
            if_state_next = lock_status_pkg::if_idle;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            if_state_reg <= lock_status_pkg::if_idle;
        end else begin
            if_state_reg <= if_state_next;
        end
    end

    // Gate timer and pulse count; clearing enable wipes the result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_reg <= 20'h00000;
            if_count_reg <= 20'h00000;
            if_done_reg <= 1'b0;
        end else if (!if_count_enable) begin
            gate_reg <= 20'h00000;
            if_count_reg <= 20'h00000;
            if_done_reg <= 1'b0;
        end else if (cte_start) begin
            gate_reg <= 20'(GATE_CYCLES);
            if_count_reg <= 20'h00000;
            if_done_reg <= 1'b0;
        end else if (if_state_reg == lock_status_pkg::if_run) begin
            gate_reg <= gate_reg - 20'h00001;
            if (if_rise && if_count_reg != 20'hfffff) begin
                if_count_reg <= if_count_reg + 20'h00001;
            end
            if (gate_reg == 20'h00001) begin
                if_done_reg <= 1'b1;
            end
        end
    end

    // Events for the interrupt status
    always_comb begin
        irq_event = 3'h0;
        irq_event[`IRQ_UNLOCK] = pd.lock_tick & ~pd.lock_ok;
        irq_event[`IRQ_RELOCK] = pd.lock_tick & pd.lock_ok & ~locked_reg;
        irq_event[`IRQ_IF_DONE] = (if_state_reg == lock_status_pkg::if_run) & (gate_reg == 20'h00001) & if_count_enable;
    end

    // Sticky status, write one to clear; a same-cycle event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= `IRQ_RESET;
        end else if (wr_commit && paddr == `OFF_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~pwdata[2:0]) | irq_event;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_event;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= `IRQ_RESET;
        end else if (wr_commit && paddr == `OFF_IRQ_MASK) begin
            irq_mask_reg <= pwdata[2:0];
        end
    end

    // Interrupt lags status by one cycle to come from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Serial output source; no data-output framing exists here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out <= 1'b0;
        end else begin
            case (out_sel)
                lock_status_pkg::out_lock: serial_out <= locked_reg;
                lock_status_pkg::out_if_done: serial_out <= if_done_reg;
                lock_status_pkg::out_port: serial_out <= port_lvl;
                lock_status_pkg::out_no_unlock: serial_out <= ~unlock_reg;
                default: serial_out <= 1'b0;
            endcase
        end
    end

    // Pump and divisor outputs straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pump_up <= 1'b0;
            pump_dn <= 1'b0;
            divisor_out <= `DIVISOR_RESET;
        end else begin
            pump_up <= pd.up;
            pump_dn <= pd.dn;
            divisor_out <= divisor_reg;
        end
    end
endmodule // lock_status_top
`default_nettype wire

/* lock_status_chk.sv */
// Checker: bus timing, output source and pump relations of lock_status_top.
// Assumes it is bound to lock_status_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module lock_status_chk (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, low
    input wire logic [11:0] paddr, // Address
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [31:0] pwdata, // Write data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic port_pin_in, // Port pin
    input wire logic serial_out, // Serial output
    input wire logic pump_up, // Pump up
    input wire logic pump_dn, // Pump down
    input wire logic irq // Interrupt
);
    logic [1:0] dz_reg, osel_reg;
    logic cte_reg;
    logic [2:0] mask_reg;
    logic wr_ok;
    // Only a completed, accepted write changes the shadows
    assign wr_ok = psel && penable && pready && pwrite && !pslverr;
    // Shadow of the control word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dz_reg <= 2'h0;
            osel_reg <= 2'h0;
            cte_reg <= 1'b0;
        end else if (wr_ok && paddr == 12'h000) begin
            dz_reg <= pwdata[1:0];
            osel_reg <= pwdata[3:2];
            cte_reg <= pwdata[4];
        end
    end
    // Shadow of the interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= 3'h0;
        end else if (wr_ok && paddr == 12'h010) begin
            mask_reg <= pwdata[2:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("ready not after one wait");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_err_decode: assert property (psel && penable && pready |-> pslverr == (paddr > 12'h014 || paddr[1:0] != 2'h0))
        else $error("error flag wrong for address");
    chk_port_copy: assert property (
        (osel_reg == 2'h2 && $stable(port_pin_in))[*8] |-> serial_out == port_pin_in)
        else $error("port level not copied");
    // Mode changes need a few cycles to flush the delayed pump pipeline
    chk_gap_exclusive: assert property (dz_reg[1] && $past(dz_reg[1], 8) |-> !(pump_up && pump_dn))
        else $error("both pump sides with a gap");
    chk_onon_paired: assert property (
        !dz_reg[1] && !$past(dz_reg[1], 8) && $rose(pump_up) |-> ##[0:40] pump_dn)
        else $error("no paired down pulse");
    chk_irq_masked: assert property (mask_reg == 3'h0 && $past(mask_reg) == 3'h0 |-> !irq)
        else $error("interrupt while all masked");
    chk_done_cleared: assert property ((osel_reg == 2'h1 && !cte_reg)[*3] |-> !serial_out)
        else $error("count done shown while cleared");
endmodule // lock_status_chk
bind lock_status_top lock_status_chk i_lock_status_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .port_pin_in(port_pin_in), .serial_out(serial_out), .pump_up(pump_up), .pump_dn(pump_dn), .irq(irq));
`default_nettype wire

/* loop_model.sv */
// Loop model: reference and divided oscillator phases with a set lag.
// Assumes a 40-cycle reference period on pclk and a lag below it.
`timescale 1ns/1ps
`default_nettype none
module loop_model (
    input wire logic pclk, // Clock
    input wire logic [5:0] lag, // Oscillator lag, cycles
    output logic ref_out, // Reference phase
    output logic osc_out // Divided oscillator phase
);
    logic [5:0] cnt = 6'h00;
    // Free running: a real loop never stops its phases
    always_ff @(posedge pclk) begin
        cnt <= (cnt == 6'h27) ? 6'h00 : cnt + 6'h01;
        ref_out <= cnt < 6'h14;
        osc_out <= (int'(cnt) + 40 - int'(lag)) % 40 < 20;
    end
endmodule // loop_model
`default_nettype wire

/* lock_status_top_bench.sv */
// Bench for lock_status_top: APB master, pins and loop model.
// Assumes a shortened IF gate and a 40-cycle reference period.
`timescale 1ns/1ps
`default_nettype none
`include "lock_status_defines.svh"
module lock_status_top_bench;
    localparam int GATE = 50;
    logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, ref_ph, osc_ph, serial_out, pump_up, pump_dn, irq, err, both_seen;
    logic if_in = 1'b0, sd = 1'b0, port_in = 1'b0, if_on = 1'b0;
    logic [15:0] divisor_out, dv;
    logic [5:0] lag = 6'h02;
    int n_errors = 0, check_count = 0, seed = 96473, cyc = 0;
    lock_status_top #(.GATE_CYCLES(GATE)) i_lock_status_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_phase_in(ref_ph), .osc_phase_in(osc_ph), .if_signal_input(if_in),
        .station_detect(sd), .port_pin_in(port_in), .serial_out(serial_out), .pump_up(pump_up),
        .pump_dn(pump_dn), .divisor_out(divisor_out), .irq(irq));
    loop_model i_loop_model (.pclk(pclk), .lag(lag), .ref_out(ref_ph), .osc_out(osc_ph));
    always #5 pclk = ~pclk;
    // IF pulses every 8 cycles; hang guard far above the fewer than two thousand needed
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if_in <= if_on & cyc[2];
        if (pump_up === 1'b1 && pump_dn === 1'b1) both_seen <= 1'b1;
        if (cyc >= 20000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask
    // Status word built from the field positions
    function automatic logic [31:0] status_word(input logic lk, input logic ul, input logic sdt, input logic onon);
        status_word = 32'h0;
        status_word[`ST_LOCKED] = lk;
        status_word[`ST_UNLOCK] = ul;
        status_word[`ST_STATION] = sdt;
        status_word[`ST_ONON] = onon;
    endfunction
    // One transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
        if (n >= 20) begin
            n_errors++;
            end_sim();
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk32(rd, exp);
    endtask
    initial begin
        presetn <= 1'b0; // A real falling edge, or the async resets never fire
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`OFF_CTRL, 32'h0);
        rdchk(`OFF_IRQ_MASK, 32'h0);
        rdchk(12'h100, 32'h0);
        chk1(err, 1'b1);
        dv = 16'($random(seed));
        apb(1'b1, `OFF_DIVISOR, {16'h0, dv});
        repeat (120) @(posedge pclk);
        chk32({16'h0, divisor_out}, {16'h0, dv});
        chk1(serial_out, 1'b1);
        lag <= 6'h0f;
        repeat (120) @(posedge pclk);
        chk1(serial_out, 1'b0);
        lag <= 6'h02;
        repeat (120) @(posedge pclk);
        chk1(serial_out, 1'b1);
        rdchk(`OFF_STATUS, status_word(1'b1, 1'b1, 1'b0, 1'b1));
        rdchk(`OFF_STATUS, status_word(1'b1, 1'b0, 1'b0, 1'b1));
        // Sticky events stay hidden until unmasked
        rdchk(`OFF_IRQ_STAT, 32'h3);
        chk1(irq, 1'b0);
        apb(1'b1, `OFF_IRQ_MASK, 32'h2);
        repeat (3) @(posedge pclk);
        chk1(irq, 1'b1);
        apb(1'b1, `OFF_IRQ_STAT, 32'h2);
        repeat (3) @(posedge pclk);
        chk1(irq, 1'b0);
        rdchk(`OFF_IRQ_STAT, 32'h1);
        apb(1'b1, `OFF_CTRL, 32'h8);
        for (int i = 0; i < 6; i++) begin
            port_in <= 1'($random(seed));
            repeat (8) @(posedge pclk);
            chk1(serial_out, port_in);
        end
        {sd, port_in} <= 2'h2;
        apb(1'b1, `OFF_CTRL, 32'h4);
        repeat (6) @(posedge pclk);
        rdchk(`OFF_STATUS, status_word(1'b1, 1'b0, 1'b1, 1'b1));
        // Counting is started only with station detect present
        if (rd[3] === 1'b1) begin
            if_on <= 1'b1;
            apb(1'b1, `OFF_CTRL, 32'h14);
        end
        repeat (GATE + 20) @(posedge pclk);
        chk1(serial_out, 1'b1);
        rdchk(`OFF_IRQ_STAT, 32'h5);
        // IF edges every 8 cycles: a 50-cycle gate holds six or seven
        apb(1'b0, `OFF_IF_COUNT, 32'h0);
        chk1(rd[19:0] >= 20'h00006 && rd[19:0] <= 20'h00007, 1'b1);
        apb(1'b1, `OFF_CTRL, 32'h4);
        repeat (3) @(posedge pclk);
        chk1(serial_out, 1'b0);
        rdchk(`OFF_IF_COUNT, 32'h0);
        if_on <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, `OFF_CTRL, 32'(m));
            repeat (10) @(posedge pclk);
            both_seen <= 1'b0;
            repeat (120) @(posedge pclk);
            chk1(both_seen, m < 2);
            rdchk(`OFF_STATUS, status_word(1'b1, 1'b0, 1'b1, m < 2));
        end
        // Inverse unlock source: a loss of lock stays visible after relock
        apb(1'b1, `OFF_CTRL, 32'hc);
        repeat (3) @(posedge pclk);
        chk1(serial_out, 1'b1);
        lag <= 6'h0f;
        repeat (120) @(posedge pclk);
        lag <= 6'h02;
        repeat (120) @(posedge pclk);
        chk1(serial_out, 1'b0);
        end_sim();
    end
endmodule // lock_status_top_bench
`default_nettype wire
